// file: verilog/lin_register_map_decoder.sv
// Register bank between the LIN frame logic and the regulator core.
// Assumes frame fields, strobes and measurements come from logic on
// ref_clk, so none of them is synchronised here.
//
// Functional notes
// - Timeout without valid frame restores all writable registers to defaults.
// - RX fields load registers only when the select field is not 110.
// - TX3 fields are valid only while the echoed select is not 110.
// - Version A: setpoint bits 7..2 from six-bit field, low bits zero.
// - Version B: setpoint loads all eight bits from the field.
// - Cool: setpoint 10.6 V plus 25 mV per step, clamped at 16 V above 216.
// - Hot with code above 216: 16 V minus slope times temperature excess.
// - Version A rise time: 0 disables, code n gives n seconds.
// - Version B rise time: 0.25/0.5/0.75, 1..10, 12 and 15 seconds.
// - Speed cutoff 2400 to 8000 rpm; code 1111 never cuts off.
// - Blind zone bit selects alpha 3 percent or 12 percent.
// - Version A limit: low five bits from field, 0.25 A per step.
// - Version B limit: seven bits from field bits 7..1, 0.1 A per step.
// - Version A cap: none at 0, 2 A below 8, else code times 0.25 A.
// - Version B cap: none at 0, 0.1 A steps, 11 A at 110, none above.
// - Removed or raised cap with ramp enabled engages the ramp.
// - TX3 byte by select: setpoint, battery, die temp, zeros.
// - Select 000 or 111 sends zeros and defaults zone, thermal, paramset.
// - Version A select 001: setpoint bits 7..2 in byte bits 5..0.
// - Version B select 001: full setpoint in the byte.
// - Fine current goes to TX3 current field in both versions.
// - Version A coarse current goes to the TX1 current field.
// - Failure and timeout flags stick until read; others follow live.
`timescale 1ns/1ps

module lin_register_map_decoder #(
    parameter int unsigned TIMEOUT_CYCLES = (lin_regmap_pkg::COMM_TIMEOUT_MS
        * (lin_regmap_pkg::PS_PER_MS / lin_regmap_pkg::CLK_PERIOD_PS)),
    parameter int unsigned SLOPE_W = 8
) (
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic clkEn,
    input wire logic versionB,
    input wire logic rxFrameValid,
    input wire logic [7:0] setpoint_rx_field,
    input wire logic zoneRxField,
    input wire logic [3:0] rise_rx_field,
    input wire logic [3:0] cutoff_rx_field,
    input wire logic [7:0] limitRxField,
    input wire logic [2:0] select_rx_field,
    input wire logic [2:0] thermal_rx_field,
    input wire logic paramset_rx_field,
    input wire logic commErrorPulse,
    input wire logic flagReadPulse,
    input wire logic dieHot,
    input wire logic [7:0] hotExcessDeg,
    input wire logic [SLOPE_W-1:0] hot_derating_slope,
    input wire logic hot_die_flag,
    input wire logic rotor_fault_flag,
    input wire logic electrical_fault_flag,
    input wire logic [4:0] field_duty_readback,
    input wire logic [5:0] field_current_coarse,
    input wire logic [7:0] field_current_fine,
    input wire logic [7:0] battery_voltage_readback,
    input wire logic [7:0] die_temp_readback,
    output logic [7:0] voltage_setpoint_reg,
    output logic ramp_blind_zone,
    output logic [3:0] ramp_rise_time,
    output logic [3:0] ramp_speed_cutoff,
    output logic [6:0] excitation_limit_reg,
    output logic [2:0] thermal_threshold_adjust,
    output logic [2:0] response_select_code,
    output logic parameter_set_select,
    output logic defaultMode,
    output logic [15:0] regulation_setpoint_volts,
    output logic [15:0] riseTimeMs,
    output logic rampEnabled,
    output logic [15:0] cutoffRpm,
    output logic cutoffActive,
    output logic [3:0] ramp_alpha_zone,
    output logic [15:0] excitation_current_cap,
    output logic capActive,
    output logic rampEngage,
    output logic comm_failure_flag,
    output logic comm_timeout_flag,
    output logic [7:0] tx3_selectable_byte,
    output logic [2:0] tx3_indicator_echo,
    output logic [7:0] tx3_current_field,
    output logic [5:0] tx1_current_field,
    output logic [4:0] tx1DutyField,
    output logic [4:0] tx3DutyField,
    output logic [4:0] tx1FlagField,
    output logic [4:0] tx3FlagField,
    output logic tx3Valid
);
    // Elaboration check: a zero timeout would wrap the compare value to all ones
    if (TIMEOUT_CYCLES < 1 || SLOPE_W < 1 || SLOPE_W > 8) begin : g_chk
        $error("lin_register_map_decoder: bad parameter value");
    end

    // Rise time in milliseconds; both versions share code 0 as off
    function automatic logic [15:0] rise_ms(input logic verB,
                                            input logic [3:0] code);
        logic [15:0] ms;
        ms = 16'h0000;
        if (!verB) begin
            ms = 16'({12'h000, code} * 16'h03e8);
        end else begin
            unique case (code)
                4'h0: ms = 16'h0000;
                4'h1: ms = 16'h00fa;
                4'h2: ms = 16'h01f4;
                4'h3: ms = 16'h02ee;
                4'he: ms = 16'h2ee0;
                4'hf: ms = 16'h3a98;
                default: ms = 16'((code - 4'h3) * 16'h03e8);
            endcase
        end
        return ms;
    endfunction

    // Rotor speed cutoff in rpm; the top code means no cutoff
    function automatic logic [15:0] cutoff_rpm(input logic [3:0] code);
        logic [15:0] rpm;
        rpm = 16'h0000;
        unique case (code)
            4'h0: rpm = 16'h0960;
            4'h1: rpm = 16'h09e2;
            4'h2: rpm = 16'h0a6e;
            4'h3: rpm = 16'h0b04;
            4'h4: rpm = 16'h0bb8;
            4'h5: rpm = 16'h0c80;
            4'h6: rpm = 16'h0d66;
            4'h7: rpm = 16'h0e6a;
            4'h8: rpm = 16'h0fa0;
            4'h9: rpm = 16'h1108;
            4'ha: rpm = 16'h12c0;
            4'hb: rpm = 16'h14d2;
            4'hc: rpm = 16'h1770;
            4'hd: rpm = 16'h1acc;
            4'he: rpm = 16'h1f40;
            4'hf: rpm = 16'h0000;
        endcase
        return rpm;
    endfunction

    // Current cap in mA; bit 16 set means a cap applies
    function automatic logic [16:0] cap_ma(input logic verB,
                                           input logic [6:0] code);
        logic [16:0] r;
        r = 17'h00000;
        if (code == 7'h00) begin
            r = 17'h00000;
        end else if (!verB) begin
            if (code < lin_regmap_pkg::LIMIT_A_FLOOR_CODE) begin
                r = {1'b1, lin_regmap_pkg::LIMIT_A_FLOOR_MA};
            end else begin
                r = {1'b1, 16'({9'h000, code}
                    * lin_regmap_pkg::LIMIT_A_STEP_MA)};
            end
        end else if (code < lin_regmap_pkg::LIMIT_B_TOP_CODE) begin
            r = {1'b1, 16'({9'h000, code} * lin_regmap_pkg::LIMIT_B_STEP_MA)};
        end else if (code == lin_regmap_pkg::LIMIT_B_TOP_CODE) begin
            r = {1'b1, lin_regmap_pkg::LIMIT_B_TOP_MA};
        end else begin
            r = 17'h00000;
        end
        return r;
    endfunction

    // Frame acceptance and select classes
    wire logic frameTaken = rxFrameValid && clkEn;
    wire logic rxLoad = frameTaken
        && (select_rx_field != lin_regmap_pkg::SEL_RESERVED);
    wire logic rxIgnoreSet = (select_rx_field == lin_regmap_pkg::SEL_NONE_A)
        || (select_rx_field == lin_regmap_pkg::SEL_NONE_B);

    wire logic [7:0] setpointIn = versionB ? setpoint_rx_field
        : {setpoint_rx_field[5:0], 2'b00};
    wire logic [6:0] limitIn = versionB
        ? limitRxField[7:lin_regmap_pkg::LIMIT_B_LSB]
        : {2'b00, limitRxField[4:0]};

    // Timeout counter
    logic [31:0] idleCount_reg;
    wire logic timeoutHit = clkEn && !rxLoad
        && (idleCount_reg == 32'(TIMEOUT_CYCLES - 1));

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            idleCount_reg <= 32'h00000000;
        end else if (clkEn) begin
            if (rxLoad || timeoutHit) begin
                idleCount_reg <= 32'h00000000;
            end else begin
                idleCount_reg <= idleCount_reg + 32'h00000001;
            end
        end
    end

    // Writable registers
    // timeout restores defaults
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            voltage_setpoint_reg <= lin_regmap_pkg::SETPOINT_DEFAULT;
            ramp_rise_time <= lin_regmap_pkg::RISE_DEFAULT;
            ramp_speed_cutoff <= lin_regmap_pkg::CUTOFF_DEFAULT;
            excitation_limit_reg <= lin_regmap_pkg::LIMIT_DEFAULT;
            response_select_code <= lin_regmap_pkg::SELECT_DEFAULT;
        end else if (timeoutHit) begin
            voltage_setpoint_reg <= lin_regmap_pkg::SETPOINT_DEFAULT;
            ramp_rise_time <= lin_regmap_pkg::RISE_DEFAULT;
            ramp_speed_cutoff <= lin_regmap_pkg::CUTOFF_DEFAULT;
            excitation_limit_reg <= lin_regmap_pkg::LIMIT_DEFAULT;
            response_select_code <= lin_regmap_pkg::SELECT_DEFAULT;
        end else if (rxLoad) begin
            voltage_setpoint_reg <= setpointIn;
            ramp_rise_time <= rise_rx_field;
            ramp_speed_cutoff <= cutoff_rx_field;
            excitation_limit_reg <= limitIn;
            response_select_code <= select_rx_field;
        end
    end

    // Zone, thermal and parameter set also fall back on select 000/111
    // ignored-select defaults
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            ramp_blind_zone <= lin_regmap_pkg::BLIND_ZONE_DEFAULT;
            thermal_threshold_adjust <= lin_regmap_pkg::THERMAL_DEFAULT;
            parameter_set_select <= lin_regmap_pkg::PARAMSET_DEFAULT;
        end else if (timeoutHit || (rxLoad && rxIgnoreSet)) begin
            ramp_blind_zone <= lin_regmap_pkg::BLIND_ZONE_DEFAULT;
            thermal_threshold_adjust <= lin_regmap_pkg::THERMAL_DEFAULT;
            parameter_set_select <= lin_regmap_pkg::PARAMSET_DEFAULT;
        end else if (rxLoad) begin
            ramp_blind_zone <= zoneRxField;
            thermal_threshold_adjust <= thermal_rx_field;
            parameter_set_select <= paramset_rx_field;
        end
    end

    // Default operation holds from timeout until the next good frame
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            defaultMode <= 1'b1;
        end else if (timeoutHit) begin
            defaultMode <= 1'b1;
        end else if (rxLoad) begin
            defaultMode <= 1'b0;
        end
    end

    // Sticky flags; a set in the clearing cycle wins over the read
    // latched until read
    wire logic failNext = (clkEn && commErrorPulse)
        || (comm_failure_flag && !(clkEn && flagReadPulse));
    wire logic ctoNext = timeoutHit
        || (comm_timeout_flag && !(clkEn && flagReadPulse));

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            comm_failure_flag <= 1'b0;
            comm_timeout_flag <= 1'b0;
        end else begin
            comm_failure_flag <= failNext;
            comm_timeout_flag <= ctoNext;
        end
    end

    // Setpoint arithmetic; the hot reduction saturates at zero volts
    // linear range and clamp
    wire logic [15:0] linearMv = 16'(lin_regmap_pkg::SETPOINT_BASE_MV
        + 16'({8'h00, voltage_setpoint_reg}
        * lin_regmap_pkg::SETPOINT_STEP_MV));
    wire logic setpointHigh =
        voltage_setpoint_reg > lin_regmap_pkg::SETPOINT_LINEAR_TOP;
    wire logic [15:0] hotDropMv = 16'({8'h00, hotExcessDeg}
        * {8'h00, 8'(hot_derating_slope)});
    wire logic [15:0] hotMv = (hotDropMv >= lin_regmap_pkg::SETPOINT_MAX_MV)
        ? 16'h0000 : 16'(lin_regmap_pkg::SETPOINT_MAX_MV - hotDropMv);
    wire logic [15:0] setpointNext = !setpointHigh ? linearMv
        : (dieHot ? hotMv : lin_regmap_pkg::SETPOINT_MAX_MV);

    wire logic [16:0] capDec = cap_ma(versionB, excitation_limit_reg);
    wire logic capNext = capDec[16] && !defaultMode;
    wire logic [15:0] capMaNext = capNext ? capDec[15:0] : 16'h0000;
    wire logic rampNext = ramp_rise_time != lin_regmap_pkg::RAMP_OFF_CODE;
    // cap removed or raised while ramp is on
    wire logic engageNext = rampNext && capActive
        && (!capNext || (capMaNext > excitation_current_cap));

    // Decoded control values for the regulator core
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            regulation_setpoint_volts <= 16'h0000;
            riseTimeMs <= 16'h0000;
            rampEnabled <= 1'b0;
            cutoffRpm <= 16'h0000;
            cutoffActive <= 1'b0;
            ramp_alpha_zone <= lin_regmap_pkg::ALPHA_LOW_PCT;
            excitation_current_cap <= 16'h0000;
            capActive <= 1'b0;
            rampEngage <= 1'b0;
        end else if (clkEn) begin
            regulation_setpoint_volts <= setpointNext;
            riseTimeMs <= rise_ms(versionB, ramp_rise_time);
            rampEnabled <= rampNext;
            cutoffRpm <= cutoff_rpm(ramp_speed_cutoff);
            cutoffActive <=
                ramp_speed_cutoff != lin_regmap_pkg::CUTOFF_NEVER_CODE;
            ramp_alpha_zone <= ramp_blind_zone
                ? lin_regmap_pkg::ALPHA_HIGH_PCT
                : lin_regmap_pkg::ALPHA_LOW_PCT;
            excitation_current_cap <= capMaNext;
            capActive <= capNext;
            rampEngage <= engageNext;
        end else begin
            rampEngage <= 1'b0;
        end
    end

    // TX3 selectable byte by echoed select
    // setpoint echo by version
    wire logic [7:0] setpointEcho = versionB ? voltage_setpoint_reg
        : {2'b00, voltage_setpoint_reg[7:lin_regmap_pkg::SET_A_LSB]};
    wire logic [7:0] selByte =
        (response_select_code == lin_regmap_pkg::SEL_SETPOINT) ? setpointEcho
        : (response_select_code == lin_regmap_pkg::SEL_BATTERY)
            ? battery_voltage_readback
        : (response_select_code == lin_regmap_pkg::SEL_DIE_TEMP)
            ? die_temp_readback
        : 8'h00;
    wire logic [4:0] flagBus = {comm_timeout_flag, comm_failure_flag,
        electrical_fault_flag, rotor_fault_flag, hot_die_flag};

    // Transmit fields
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            tx3_selectable_byte <= 8'h00;
            tx3_indicator_echo <= lin_regmap_pkg::SELECT_DEFAULT;
            tx3_current_field <= 8'h00;
            tx1_current_field <= 6'h00;
            tx1DutyField <= 5'h00;
            tx3DutyField <= 5'h00;
            tx1FlagField <= 5'h00;
            tx3FlagField <= 5'h00;
        end else if (clkEn) begin
            tx3_selectable_byte <= selByte;
            tx3_indicator_echo <= response_select_code;
            tx3_current_field <= field_current_fine;
            tx1_current_field <= versionB ? 6'h00 : field_current_coarse;
            tx1DutyField <= field_duty_readback;
            tx3DutyField <= field_duty_readback;
            tx1FlagField <= flagBus;
            tx3FlagField <= flagBus;
        end
    end

    assign tx3Valid = tx3_indicator_echo != lin_regmap_pkg::SEL_RESERVED;

    // Checks kept beside the logic
    a_timeout_default: assert property (@(posedge ref_clk)
        disable iff (!nrst) timeoutHit |=> defaultMode && comm_timeout_flag
            && voltage_setpoint_reg == lin_regmap_pkg::SETPOINT_DEFAULT)
        else $error("timeout did not restore defaults");
    a_reserved_noload: assert property (@(posedge ref_clk)
        disable iff (!nrst)
        frameTaken && select_rx_field == lin_regmap_pkg::SEL_RESERVED
            && !timeoutHit |=> $stable(voltage_setpoint_reg))
        else $error("reserved select loaded registers");
    a_setpoint_vera: assert property (@(posedge ref_clk)
        disable iff (!nrst) rxLoad && !timeoutHit && !versionB
            |=> voltage_setpoint_reg == {$past(setpoint_rx_field[5:0]), 2'b00})
        else $error("version A setpoint load wrong");
    a_limit_verb: assert property (@(posedge ref_clk)
        disable iff (!nrst) rxLoad && !timeoutHit && versionB
            |=> excitation_limit_reg == $past(limitRxField[7:1]))
        else $error("version B limit load wrong");
    a_setpoint_clamp: assert property (@(posedge ref_clk)
        disable iff (!nrst) clkEn && setpointHigh && !dieHot
            |=> regulation_setpoint_volts == lin_regmap_pkg::SETPOINT_MAX_MV)
        else $error("setpoint not clamped to 16 V");
    a_ignore_defaults: assert property (@(posedge ref_clk)
        disable iff (!nrst) rxLoad && rxIgnoreSet |=> !ramp_blind_zone
            && !parameter_set_select && thermal_threshold_adjust == 3'h0)
        else $error("select 000/111 kept zone settings");
    a_default_nocap: assert property (@(posedge ref_clk)
        disable iff (!nrst) clkEn && defaultMode |=> !capActive)
        else $error("cap applied in default operation");
    a_flag_sticky: assert property (@(posedge ref_clk)
        disable iff (!nrst) comm_failure_flag && !flagReadPulse
            ##1 !flagReadPulse |-> comm_failure_flag)
        else $error("failure flag dropped without read");
    a_tx3_zero_sel: assert property (@(posedge ref_clk)
        disable iff (!nrst)
        clkEn && response_select_code == lin_regmap_pkg::SEL_ZEROS
            |=> tx3_selectable_byte == 8'h00)
        else $error("select 101 byte not zero");
    a_ramp_engage: assert property (@(posedge ref_clk)
        disable iff (!nrst) rampEngage |-> rampEnabled && $past(capActive))
        else $error("ramp engaged without enabled ramp");
endmodule // lin_register_map_decoder

// file: verilog/lin_regmap_pkg.sv
// Constants for the LIN register bank of the alternator regulator.
// Assumes one core clock of 250 MHz; all users name items as pkg::name.
package lin_regmap_pkg;
    // Core clock period in picoseconds
    localparam int unsigned CLK_PERIOD_PS = 4000;
    // Communication timeout period in milliseconds (value chosen here)
    localparam int unsigned COMM_TIMEOUT_MS = 10;
    localparam int unsigned PS_PER_MS = 1000000000;

    // Response-select codes
    localparam logic [2:0] SEL_NONE_A = 3'h0;
    localparam logic [2:0] SEL_SETPOINT = 3'h1;
    localparam logic [2:0] SEL_BATTERY = 3'h2;
    localparam logic [2:0] SEL_DIE_TEMP = 3'h3;
    localparam logic [2:0] SEL_RSVD_LOW = 3'h4;
    localparam logic [2:0] SEL_ZEROS = 3'h5;
    localparam logic [2:0] SEL_RESERVED = 3'h6;
    localparam logic [2:0] SEL_NONE_B = 3'h7;

    // Defaults of the writable registers
    localparam logic [7:0] SETPOINT_DEFAULT = 8'h00;
    localparam logic BLIND_ZONE_DEFAULT = 1'b0;
    localparam logic [3:0] RISE_DEFAULT = 4'h0;
    localparam logic [3:0] CUTOFF_DEFAULT = 4'hf;
    localparam logic [6:0] LIMIT_DEFAULT = 7'h00;
    localparam logic [2:0] THERMAL_DEFAULT = 3'h0;
    localparam logic [2:0] SELECT_DEFAULT = 3'h0;
    localparam logic PARAMSET_DEFAULT = 1'b0;

    // Setpoint arithmetic, millivolts
    localparam logic [15:0] SETPOINT_BASE_MV = 16'h2968; // 10600 mV
    localparam logic [15:0] SETPOINT_STEP_MV = 16'h0019; // 25 mV
    localparam logic [15:0] SETPOINT_MAX_MV = 16'h3e80; // 16000 mV
    localparam logic [7:0] SETPOINT_LINEAR_TOP = 8'hd8; // 216

    // Field positions
    localparam int unsigned SET_A_LSB = 2;
    localparam int unsigned LIMIT_B_LSB = 1;

    // Current limit arithmetic, milliamps
    localparam logic [6:0] LIMIT_A_FLOOR_CODE = 7'h08;
    localparam logic [15:0] LIMIT_A_FLOOR_MA = 16'h07d0; // 2000 mA
    localparam logic [15:0] LIMIT_A_STEP_MA = 16'h00fa; // 250 mA
    localparam logic [15:0] LIMIT_B_STEP_MA = 16'h0064; // 100 mA
    localparam logic [6:0] LIMIT_B_TOP_CODE = 7'h6e; // 110
    localparam logic [15:0] LIMIT_B_TOP_MA = 16'h2af8; // 11000 mA

    // Ramp alpha factor in percent; ramp-off and no-cutoff codes
    localparam logic [3:0] ALPHA_LOW_PCT = 4'h3;
    localparam logic [3:0] ALPHA_HIGH_PCT = 4'hc;
    localparam logic [3:0] RAMP_OFF_CODE = 4'h0;
    localparam logic [3:0] CUTOFF_NEVER_CODE = 4'hf;
endpackage

// file: tb/lin_master_model.sv
// Master-side stand-in: sends one RX frame word per call of send.
// Assumes the caller runs off the bench clock and spaces its frames.
`timescale 1ns/1ps
module lin_master_model (
    input wire logic ref_clk,
    output logic rxFrameValid,
    output logic [31:0] frameWord
);
    initial begin
        rxFrameValid = 1'b0;
        frameWord = 32'h0;
    end
    // One-cycle strobe; fields inverted after it so no stale value lingers
    task automatic send(input logic [31:0] w);
        @(negedge ref_clk);
        rxFrameValid = 1'b1;
        frameWord = w;
        @(negedge ref_clk);
        rxFrameValid = 1'b0;
        frameWord = ~w;
    endtask
endmodule // lin_master_model

// file: tb/test_lin_register_map_decoder.sv
// Self-checking bench: random RX frames compared with an integer model.
// Assumes the design keeps its own timing assertions; timeout shortened.
`timescale 1ns/1ps
module test_lin_register_map_decoder;
    logic ref_clk = 1'b0, nrst = 1'b0, clkEn = 1'b1, versionB = 1'b0;
    logic commErrorPulse = 1'b0, flagReadPulse = 1'b0, dieHot = 1'b0;
    logic hot_die_flag = 1'b0, rotor_fault_flag = 1'b0, rxFrameValid;
    logic electrical_fault_flag = 1'b0, ramp_blind_zone, tx3Valid;
    logic [7:0] hotExcessDeg = 8'h0, hot_derating_slope = 8'h0;
    logic [7:0] field_current_fine = 8'h0, battery_voltage_readback = 8'h0;
    logic [7:0] die_temp_readback = 8'h0, voltage_setpoint_reg;
    logic [5:0] field_current_coarse = 6'h0, tx1_current_field;
    logic [4:0] field_duty_readback = 5'h0, tx1DutyField, tx3DutyField;
    logic [4:0] tx1FlagField, tx3FlagField;
    logic [31:0] frameWord, w;
    logic parameter_set_select, defaultMode, rampEnabled, cutoffActive;
    logic capActive, comm_failure_flag, comm_timeout_flag, rampEngage;
    logic [3:0] ramp_rise_time, ramp_speed_cutoff, ramp_alpha_zone;
    logic [6:0] excitation_limit_reg;
    logic [2:0] thermal_threshold_adjust, response_select_code;
    logic [2:0] tx3_indicator_echo;
    logic [15:0] regulation_setpoint_volts, riseTimeMs, cutoffRpm;
    logic [15:0] excitation_current_cap;
    logic [7:0] tx3_selectable_byte, tx3_current_field;
    int mismatches = 0, comparisons = 0, cyc = 0;
    int sp = 0, zn = 0, rt = 0, co = 15, lm = 0, th = 0, se = 0, ps = 0;
    bit dm = 1'b1, tf = 1'b0, ff = 1'b0;
    int rpmTab[15] = '{2400, 2530, 2670, 2820, 3000, 3200, 3430, 3690, 4000,
        4360, 4800, 5330, 6000, 6860, 8000};

    lin_register_map_decoder #(.TIMEOUT_CYCLES(50)) i_dut (
        .*,
        .setpoint_rx_field(frameWord[31:24]), .zoneRxField(frameWord[23]),
        .rise_rx_field(frameWord[22:19]), .cutoff_rx_field(frameWord[18:15]),
        .limitRxField(frameWord[14:7]), .select_rx_field(frameWord[6:4]),
        .thermal_rx_field(frameWord[3:1]), .paramset_rx_field(frameWord[0])
    );
    lin_master_model i_master (.ref_clk, .rxFrameValid, .frameWord);

    // Clock, and a watchdog so a hang still reaches the verdict
    always #2 ref_clk = ~ref_clk;
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc > 3000) begin
            mismatches++;
            print_verdict();
        end
    end

    task automatic print_verdict();
        if (mismatches == 0 && comparisons > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] s, input int e);
        comparisons++;
        if (s !== 32'(e)) begin
            mismatches++;
            $display("BAD %s exp %0d seen %0d", nm, e, s);
        end
    endtask

    // Cap in mA from the model registers; default operation has none
    function automatic int capOf();
        if (dm || lm == 0 || (versionB && lm > 110))
            return 0;
        return versionB ? lm * 100 : (lm < 8 ? 2000 : lm * 250);
    endfunction

    // Every port but rampEngage and the two comm flags against the model; negative drop saturates at 0
    task automatic checkAll();
        int v, c, r, t;
        v = dieHot ? 16000 - int'(hotExcessDeg) * int'(hot_derating_slope)
            : 16000;
        v = (sp > 216) ? (v < 0 ? 0 : v) : 10600 + 25 * sp;
        c = capOf();
        r = !versionB ? rt * 1000 : rt < 4 ? rt * 250
            : rt < 14 ? (rt - 3) * 1000 : rt == 14 ? 12000 : 15000;
        t = se == 1 ? (versionB ? sp : sp >> 2) : se == 2
            ? battery_voltage_readback : se == 3 ? die_temp_readback : 0;
        chk("setpoint", voltage_setpoint_reg, sp);
        chk("zone", ramp_blind_zone, zn);
        chk("rise", ramp_rise_time, rt);
        chk("cutoff", ramp_speed_cutoff, co);
        chk("limit", excitation_limit_reg, lm);
        chk("thermal", thermal_threshold_adjust, th);
        chk("select", response_select_code, se);
        chk("paramset", parameter_set_select, ps);
        chk("default", defaultMode, dm);
        chk("volts", regulation_setpoint_volts, v);
        chk("cap", excitation_current_cap, c);
        chk("capon", capActive, c != 0);
        chk("risems", riseTimeMs, r);
        chk("rampon", rampEnabled, rt != 0);
        chk("rpm", cutoffRpm, co == 15 ? 0 : rpmTab[co]);
        chk("cuton", cutoffActive, co != 15);
        chk("alpha", ramp_alpha_zone, zn ? 12 : 3);
        chk("tx3byte", tx3_selectable_byte, t);
        chk("echo", tx3_indicator_echo, se);
        chk("tx3ok", tx3Valid, 1);
        chk("tx3cur", tx3_current_field, field_current_fine);
        chk("tx1cur", tx1_current_field,
            versionB ? 0 : field_current_coarse);
        chk("duty1", tx1DutyField, field_duty_readback);
        chk("duty3", tx3DutyField, field_duty_readback);
        t = {tf, ff, electrical_fault_flag, rotor_fault_flag, hot_die_flag};
        chk("flags1", tx1FlagField, t);
        chk("flags3", tx3FlagField, t);
    endtask

    // refused code leaves the model untouched
    // The engage pulse stands one cycle only, so it is looked at early
    task automatic frame(input logic [31:0] fw);
        int capOld, eng;
        capOld = capOf();
        i_master.send(fw);
        if (fw[6:4] != 3'h6) begin
            sp = versionB ? fw[31:24] : {fw[29:24], 2'b00};
            zn = fw[23];
            rt = fw[22:19];
            co = fw[18:15];
            lm = versionB ? fw[14:8] : fw[11:7];
            se = fw[6:4];
            th = fw[3:1];
            ps = fw[0];
            dm = 1'b0;
            if (se == 0 || se == 7)
                {zn, th, ps} = 0;
        end
        @(negedge ref_clk);
        eng = rt != 0 && capOld != 0 && (capOf() == 0 || capOf() > capOld);
        chk("engage", rampEngage, eng);
        @(negedge ref_clk);
        checkAll();
    endtask

    initial begin
        void'($urandom(32'h3014223b));
        repeat (16) @(negedge ref_clk);
        nrst = 1'b1;
        for (int i = 0; i < 64; i++) begin
            versionB = i[0];
            {dieHot, hot_die_flag, rotor_fault_flag, electrical_fault_flag,
                field_duty_readback} = 9'($urandom);
            {hotExcessDeg, hot_derating_slope, field_current_fine,
                battery_voltage_readback} = $urandom;
            {die_temp_readback, field_current_coarse} = 14'($urandom);
            w = $urandom;
            w[6:4] = 3'(i / 2);
            if (i % 4 == 0)
                w[31:24] = 8'hd8;
            if (i % 3 == 0)
                w[14:7] = 8'hdc;
            frame(w);
        end
        // idle link restores defaults, then read races error
        repeat (60) @(negedge ref_clk);
        {sp, zn, rt, lm, th, se, ps} = 0;
        co = 15;
        dm = 1'b1;
        tf = 1'b1;
        checkAll();
        {flagReadPulse, commErrorPulse} = 2'b11;
        @(negedge ref_clk);
        {flagReadPulse, commErrorPulse} = 2'b00;
        {ff, tf} = 2'b10;
        chk("fail", comm_failure_flag, 1);
        chk("tmo", comm_timeout_flag, 0);
        frame({$urandom} | 32'h0000_4000);
        // Enable low: a frame goes by unseen and every output stays put
        clkEn = 1'b0;
        i_master.send($urandom);
        @(negedge ref_clk);
        checkAll();
        chk("engage", rampEngage, 0);
        clkEn = 1'b1;
        print_verdict();
    end
endmodule // test_lin_register_map_decoder
